// *** design/expander_dev.sv ***
`timescale 1ns/1ps
module expander_dev
   import expander_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   serial_bus_if.dev bus,
   input wire logic addr_strap_lo,
   input wire logic addr_strap_mid,
   input wire logic addr_strap_hi,
   input wire logic [7:0] port_lines_i,
   output logic [7:0] port_lines_o,
   output logic [7:0] port_lines_oe_b,
   output logic change_alert_o,
   output logic change_alert_oe_b
);
   import expander_pkg::*;
   typedef enum logic [3:0] {
      st_idle = 4'b0001,
      st_addr = 4'b0010,
      st_rx = 4'b0100,
      st_tx = 4'b1000
   } dev_state_t;
   typedef struct packed {
      dev_state_t st;
      logic [3:0] bitn;
      logic [7:0] shift;
      logic first_byte;
      logic reading;
      logic [7:0] pointer;
      logic [7:0] drive_latch;
      logic [7:0] input_invert;
      logic [7:0] pin_direction;
      logic [7:0] captured;
      logic sda_drive_low;
      logic nack_seen;
      logic scl_d;
      logic sda_d;
   } dev_t;
   dev_t r, next_r;
   logic scl, sda;
   logic [7:0] pins;
   logic [2:0] straps;
   logic [7:0] sensed_level_bits;
   logic scl_rise, scl_fall, start_c, stop_c;
   logic [7:0] sel_value;
   pin_sync #(.width(10), .init(10'h3FF)) bus_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .raw({bus.scl_i, bus.sda_i, port_lines_i}),
      .clean({scl, sda, pins})
   );
   pin_sync #(.width(3), .init(3'h0)) strap_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .raw({addr_strap_hi, addr_strap_mid, addr_strap_lo}),
      .clean(straps)
   );
   // ---------------------------------------------------------------
   // register view
   // ---------------------------------------------------------------
   assign sensed_level_bits = pins ^ r.input_invert;
   always_comb begin
      case (r.pointer[1:0])
         sel_pin_level: sel_value = sensed_level_bits;
         sel_drive: sel_value = r.drive_latch;
         sel_invert: sel_value = r.input_invert;
         sel_dir: sel_value = r.pin_direction;
         default: sel_value = sensed_level_bits;
      endcase
   end
   assign scl_rise = scl && !r.scl_d;
   assign scl_fall = !scl && r.scl_d;
   assign start_c = scl && r.scl_d && r.sda_d && !sda;
   assign stop_c = scl && r.scl_d && !r.sda_d && sda;
   // ---------------------------------------------------------------
   // serial engine
   // ---------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.scl_d = scl;
      next_r.sda_d = sda;
      if (stop_c) begin
         next_r.st = st_idle;
         next_r.sda_drive_low = 1'b0;
      end else if (start_c) begin
         next_r.st = st_addr;
         // the clock fall that closes the start carries no bit
         next_r.bitn = '1;
         next_r.sda_drive_low = 1'b0;
      end else begin
         case (r.st)
            st_idle: begin
               next_r.sda_drive_low = 1'b0;
            end
            st_addr, st_rx: begin
               if (scl_rise && r.bitn <= bit_last) begin
                  next_r.shift = {r.shift[6:0], sda};
               end
               if (scl_fall) begin
                  next_r.bitn = r.bitn + 4'h1;
                  if (r.bitn == bit_last) begin
                     if (r.st == st_rx) begin
                        next_r.sda_drive_low = 1'b1;
                        if (r.first_byte) begin
                           next_r.pointer = r.shift;
                           next_r.first_byte = 1'b0;
                        end else begin
                           case (r.pointer[1:0])
                              sel_drive: next_r.drive_latch = r.shift;
                              sel_invert: next_r.input_invert = r.shift;
                              sel_dir: next_r.pin_direction = r.shift;
                              default: next_r.drive_latch = r.drive_latch;
                           endcase
                        end
                     end else if (r.shift[7:1] == {addr_fixed, straps}) begin
                        next_r.sda_drive_low = 1'b1;
                        next_r.reading = r.shift[0];
                        next_r.first_byte = 1'b1;
                     end else begin
                        next_r.st = st_idle;
                     end
                  end else if (r.bitn == bit_ack) begin
                     next_r.bitn = 4'h0;
                     next_r.sda_drive_low = 1'b0;
                     if (r.reading) begin
                        next_r.st = st_tx;
                        next_r.sda_drive_low = !r.shift[7];
                        next_r.shift = {r.shift[6:0], 1'b1};
                     end else begin
                        next_r.st = st_rx;
                     end
                  end
               end
               if (scl_rise && r.bitn == bit_ack && r.st == st_addr && r.shift[0]) begin
                  next_r.shift = sel_value;
                  if (r.pointer[1:0] == sel_pin_level) begin
                     next_r.captured = pins;
                  end
               end
            end
            st_tx: begin
               if (scl_rise && r.bitn == bit_ack) begin
                  next_r.nack_seen = sda;
                  next_r.shift = sel_value;
                  if (r.pointer[1:0] == sel_pin_level) begin
                     next_r.captured = pins;
                  end
               end
               if (scl_fall) begin
                  next_r.bitn = r.bitn + 4'h1;
                  if (r.bitn < bit_last) begin
                     next_r.sda_drive_low = !r.shift[7];
                     next_r.shift = {r.shift[6:0], 1'b1};
                  end else if (r.bitn == bit_last) begin
                     next_r.sda_drive_low = 1'b0;
                  end else begin
                     next_r.bitn = 4'h0;
                     if (r.nack_seen) begin
                        next_r.st = st_idle;
                     end else begin
                        next_r.sda_drive_low = !r.shift[7];
                        next_r.shift = {r.shift[6:0], 1'b1};
                     end
                  end
               end
            end
            default: next_r.st = st_idle;
         endcase
      end
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '{st: st_idle, bitn: 4'h0, shift: 8'h00, first_byte: 1'b0, reading: 1'b0,
                pointer: 8'h00, drive_latch: drive_reset, input_invert: invert_reset,
                pin_direction: dir_reset, captured: 8'hFF, sda_drive_low: 1'b0,
                nack_seen: 1'b0, scl_d: 1'b1, sda_d: 1'b1};
      end else begin
         r <= next_r;
      end
   end
   // ---------------------------------------------------------------
   // pins
   // ---------------------------------------------------------------
   assign bus.sda_dev_o = 1'b0;
   assign bus.sda_dev_oe_b = !r.sda_drive_low;
   assign port_lines_o = r.drive_latch;
   assign port_lines_oe_b = r.pin_direction;
   assign change_alert_o = 1'b0;
   assign change_alert_oe_b = ((pins ^ r.captured) & r.pin_direction) == 8'h00;
endmodule // expander_dev

// *** design/expander_host.sv ***
`timescale 1ns/1ps
module expander_host
   import expander_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   serial_bus_if.host bus,
   input wire logic [1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata
);
   import expander_pkg::*;
   typedef enum logic [5:0] {
      hs_idle = 6'b000001,
      hs_start = 6'b000010,
      hs_bit = 6'b000100,
      hs_ack = 6'b001000,
      hs_rstart = 6'b010000,
      hs_stop = 6'b100000
   } host_state_t;
   // go word: [15] read, [14:8] address, [7:0] command; data word: byte to write
   typedef struct packed {
      host_state_t st;
      logic [7:0] div;
      logic phase;
      logic [1:0] step;
      logic [3:0] bitn;
      logic [7:0] shift;
      logic [7:0] cmd;
      logic [6:0] dev_addr;
      logic [7:0] wbyte;
      logic do_read;
      logic [1:0] stage;
      logic scl_low;
      logic sda_low;
      logic nacked;
      logic [7:0] rbyte;
      logic [15:0] rdata;
   } host_t;
   host_t r, next_r;
   logic sda;
   logic tick;
   pin_sync #(.width(1), .init(1'b1)) sda_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .raw(bus.sda_i),
      .clean(sda)
   );
   assign tick = r.div == 8'h00;
   always_comb begin
      next_r = r;
      next_r.div = tick ? scl_half_cycles - 8'h01 : r.div - 8'h01;
      next_r.rdata = 16'h0000;
      if (rd) begin
         case (addr)
            ctl_status: next_r.rdata = {14'h0000, r.nacked, r.st != hs_idle};
            ctl_rdata: next_r.rdata = {8'h00, r.rbyte};
            default: next_r.rdata = 16'h0000;
         endcase
      end
      if (wr && addr == ctl_data) begin
         next_r.wbyte = wdata[7:0];
      end
      case (r.st)
         hs_idle: begin
            next_r.scl_low = 1'b0;
            next_r.sda_low = 1'b0;
            if (wr && addr == ctl_go) begin
               next_r.do_read = wdata[15];
               next_r.dev_addr = wdata[14:8];
               next_r.cmd = wdata[7:0];
               next_r.nacked = 1'b0;
               next_r.stage = 2'h0;
               next_r.st = hs_start;
            end
         end
         hs_start, hs_rstart: if (tick) begin
            next_r.step = r.step + 2'h1;
            case (r.step)
               2'h0: next_r.sda_low = 1'b0;
               2'h1: next_r.scl_low = 1'b0;
               2'h2: next_r.sda_low = 1'b1;
               default: begin
                  next_r.scl_low = 1'b1;
                  next_r.st = hs_bit;
                  next_r.bitn = 4'h0;
                  next_r.shift = {r.dev_addr, r.st == hs_rstart};
               end
            endcase
         end
         hs_bit: if (tick) begin
            if (r.scl_low && !r.phase) begin
               // data moves mid low phase, never beside the clock edge
               next_r.sda_low = (r.stage == 2'h3) ? 1'b0 : !r.shift[7];
               next_r.phase = 1'b1;
            end else if (r.scl_low) begin
               next_r.scl_low = 1'b0;
               next_r.phase = 1'b0;
            end else begin
               next_r.scl_low = 1'b1;
               next_r.shift = {r.shift[6:0], sda};
               next_r.bitn = r.bitn + 4'h1;
               if (r.bitn == bit_last) begin
                  next_r.st = hs_ack;
               end
            end
         end
         hs_ack: if (tick) begin
            if (r.scl_low && !r.phase) begin
               // reading: nack the single byte wanted
               next_r.sda_low = 1'b0;
               next_r.phase = 1'b1;
            end else if (r.scl_low) begin
               next_r.scl_low = 1'b0;
               next_r.phase = 1'b0;
            end else begin
               next_r.scl_low = 1'b1;
               next_r.bitn = 4'h0;
               next_r.step = 2'h0;
               if (r.stage == 2'h3) begin
                  next_r.rbyte = r.shift;
                  next_r.st = hs_stop;
               end else if (sda) begin
                  next_r.nacked = 1'b1;
                  next_r.st = hs_stop;
               end else if (r.stage == 2'h0) begin
                  next_r.stage = 2'h1;
                  next_r.shift = r.cmd;
                  next_r.st = hs_bit;
               end else if (r.stage == 2'h1 && r.do_read) begin
                  // stage 2 of a read is the address resent after restart
                  next_r.stage = 2'h2;
                  next_r.st = hs_rstart;
               end else if (r.stage == 2'h1) begin
                  next_r.stage = 2'h2;
                  next_r.shift = r.wbyte;
                  next_r.st = hs_bit;
               end else if (r.do_read) begin
                  next_r.stage = 2'h3;
                  next_r.shift = 8'hFF;
                  next_r.st = hs_bit;
               end else begin
                  next_r.st = hs_stop;
               end
            end
         end
         hs_stop: if (tick) begin
            next_r.step = r.step + 2'h1;
            case (r.step)
               2'h0: next_r.sda_low = 1'b1;
               2'h1: next_r.scl_low = 1'b0;
               2'h2: next_r.sda_low = 1'b0;
               default: next_r.st = hs_idle;
            endcase
         end
         default: next_r.st = hs_idle;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '{st: hs_idle, div: 8'h00, phase: 1'b0, step: 2'h0, bitn: 4'h0,
                shift: 8'h00, cmd: 8'h00, dev_addr: 7'h00, wbyte: 8'h00, do_read: 1'b0,
                stage: 2'h0, scl_low: 1'b0, sda_low: 1'b0, nacked: 1'b0, rbyte: 8'h00,
                rdata: 16'h0000};
      end else begin
         r <= next_r;
      end
   end
   assign rdata = r.rdata;
   assign bus.scl_o = 1'b0;
   assign bus.scl_oe_b = !r.scl_low;
   assign bus.sda_host_o = 1'b0;
   assign bus.sda_host_oe_b = !r.sda_low;
endmodule // expander_host

// *** design/expander_pkg.sv ***
// ---------------------------------------------------------------
// Overview of operation
// - answer addresses 0x38..0x3F via straps
// - address lsb one reads, zero writes
// - first written byte loads register pointer
// - pointer low bits pick one of four
// - pointer holds until next command byte
// - input register returns live pin levels
// - writes to input register are ignored
// - latch drives only output pins, resets ones
// - latch reads return flip-flop contents
// - invert bit flips sensed input, resets zero
// - direction one means input, resets ones
// - no pointer advance, last write byte wins
// - master writes start, address, command, data, stop
// - read uses command write then restart
// - repeated reads return same register
// - transmit byte captured at acknowledge rising edge
// - master nacks last byte, then stops
// - stop ends transfer anywhere, data kept
// - alert on input change, clears on input register read
// - device acknowledges its own address and every written byte
// - reset restores registers and serial state
// ---------------------------------------------------------------
package expander_pkg;
   localparam logic [3:0] addr_fixed = 4'h7;
   localparam logic [1:0] sel_pin_level = 2'h0;
   localparam logic [1:0] sel_drive = 2'h1;
   localparam logic [1:0] sel_invert = 2'h2;
   localparam logic [1:0] sel_dir = 2'h3;
   localparam logic [7:0] drive_reset = 8'hFF;
   localparam logic [7:0] invert_reset = 8'h00;
   localparam logic [7:0] dir_reset = 8'hFF;
   localparam logic [3:0] bit_last = 4'h7;
   localparam logic [3:0] bit_ack = 4'h8;
   // controller command port
   localparam logic [1:0] ctl_go = 2'h0;
   localparam logic [1:0] ctl_data = 2'h1;
   localparam logic [1:0] ctl_status = 2'h2;
   localparam logic [1:0] ctl_rdata = 2'h3;
   // serial clock tick in mclk cycles (160 ns): scl high for one tick, low for two
   localparam int scl_half_ns = 160;
   localparam int mclk_ns = 40;
   localparam logic [7:0] scl_half_cycles = 8'(scl_half_ns / mclk_ns);
endpackage

// *** design/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
   parameter int width = 1,
   parameter logic [width-1:0] init = '1
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [width-1:0] raw,
   output logic [width-1:0] clean
);
   typedef struct packed {
      logic [width-1:0] s1;
      logic [width-1:0] s2;
      logic [width-1:0] s3;
      logic [width-1:0] q;
   } sync_t;
   sync_t r, next_r;
   always_comb begin
      next_r = r;
      next_r.s1 = raw;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < width; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            next_r.q[i] = r.s3[i];
         end
      end
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         r <= {4{init}};
      end else begin
         r <= next_r;
      end
   end
   assign clean = r.q;
endmodule // pin_sync

// *** design/serial_bus_if.sv ***
`timescale 1ns/1ps
interface serial_bus_if;
   logic scl_o;
   logic scl_oe_b;
   logic sda_host_o;
   logic sda_host_oe_b;
   logic sda_dev_o;
   logic sda_dev_oe_b;
   logic scl_i;
   logic sda_i;
   modport host (output scl_o, scl_oe_b, sda_host_o, sda_host_oe_b, input scl_i, sda_i);
   modport dev (output sda_dev_o, sda_dev_oe_b, input scl_i, sda_i);
endinterface

// *** tb/expander_chk.sv ***
`timescale 1ns/1ps
module expander_chk (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic scl_o,
   input wire logic scl_oe_b,
   input wire logic sda_host_o,
   input wire logic sda_host_oe_b,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe_b,
   input wire logic scl_i,
   input wire logic sda_i
);
   // ----------
   // frame tracking
   // ----------
   logic scl_q, sda_q, first, rdir, sel, scl_rise, start_d, ack9;
   logic [3:0] cnt;
   assign scl_rise = scl_i && !scl_q;
   assign start_d = scl_i && scl_q && sda_q && !sda_i;
   assign ack9 = scl_rise && (cnt == 4'h8);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         cnt <= 4'h0;
         first <= 1'b0;
         rdir <= 1'b0;
         sel <= 1'b0;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
         if (start_d) begin
            cnt <= 4'h0;
            first <= 1'b1;
            sel <= 1'b0;
         end else if (scl_rise) begin
            cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
            if (cnt == 4'h9) first <= 1'b0;
            if (first && cnt == 4'h7) rdir <= sda_i;
         end else if (scl_q && !scl_i && first && cnt == 4'h9) begin
            sel <= !sda_q;
         end
      end
   end
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_start;
      scl_i && $past(scl_i) && $fell(sda_i);
   endsequence
   sequence s_stop;
      scl_i && $past(scl_i) && $rose(sda_i);
   endsequence
   chk_scl_high_time: assert property ($rose(scl_i) |-> scl_i[*4])
      else $error("scl high phase too short");
   chk_scl_low_time: assert property ($fell(scl_i) |-> !scl_i[*4])
      else $error("scl low phase too short");
   chk_start_clock: assert property (s_start |-> ##[1:16] !scl_i)
      else $error("no clock after start");
   chk_dev_data_stable: assert property ($changed(sda_dev_oe_b) |-> !scl_i)
      else $error("device changed sda while scl high");
   chk_addr_quiet: assert property (first && scl_i && scl_q && cnt != 4'h9 |-> sda_dev_oe_b)
      else $error("device drove sda during address");
   chk_foreign_quiet: assert property (!first && !sel |-> sda_dev_oe_b)
      else $error("device drove sda when not selected");
   chk_write_ack: assert property (ack9 && !first && !rdir && sel |-> ##2 !sda_dev_oe_b)
      else $error("written byte not acknowledged");
   chk_read_nack: assert property (ack9 && !first && rdir |-> ##2 sda_i)
      else $error("read ack slot not released");
   chk_stop_after: assert property (ack9 && !first && rdir |-> ##[1:40] s_stop)
      else $error("no stop after final read byte");
endmodule // expander_chk

// *** tb/i2c_eight_bit_port_expander_regs_tb.sv ***
`timescale 1ns/1ps
module i2c_eight_bit_port_expander_regs_tb;
   import expander_pkg::*;
   logic mclk, rst_b, wr, rd, alert_o, alert_oe_b, nak;
   logic [1:0] addr, r;
   logic [2:0] straps;
   logic [15:0] wdata, rdata;
   logic [7:0] ext, pins, p_o, p_oe_b, latch, inv, dir, got, c, d;
   int fails, checks_done, seed, i;
   serial_bus_if sbus();
   assign sbus.scl_i = sbus.scl_oe_b ? 1'b1 : 1'b0;
   assign sbus.sda_i = (sbus.sda_host_oe_b && sbus.sda_dev_oe_b) ? 1'b1 : 1'b0;
   assign pins = (p_oe_b & ext) | (~p_oe_b & p_o);
   expander_host u_expander_host (.mclk(mclk), .rst_b(rst_b), .bus(sbus.host), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   expander_dev u_expander_dev (.mclk(mclk), .rst_b(rst_b), .bus(sbus.dev),
      .addr_strap_lo(straps[0]), .addr_strap_mid(straps[1]), .addr_strap_hi(straps[2]),
      .port_lines_i(pins), .port_lines_o(p_o), .port_lines_oe_b(p_oe_b),
      .change_alert_o(alert_o), .change_alert_oe_b(alert_oe_b));
   expander_chk u_chk (.mclk(mclk), .rst_b(rst_b), .scl_o(sbus.scl_o), .scl_oe_b(sbus.scl_oe_b),
      .sda_host_o(sbus.sda_host_o), .sda_host_oe_b(sbus.sda_host_oe_b),
      .sda_dev_o(sbus.sda_dev_o), .sda_dev_oe_b(sbus.sda_dev_oe_b),
      .scl_i(sbus.scl_i), .sda_i(sbus.sda_i));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // ----------
   // helpers
   // ----------
   function automatic logic [7:0] exp_reg(input logic [1:0] s);
      case (s)
         2'h0: exp_reg = ((dir & ext) | (~dir & latch)) ^ inv;
         2'h1: exp_reg = latch;
         2'h2: exp_reg = inv;
         default: exp_reg = dir;
      endcase
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic end_of_test;
      if (fails == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic reg_wr(input logic [1:0] a, input logic [15:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [1:0] a, output logic [15:0] v);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   task automatic xfer(input logic r_w, input logic [6:0] a7, input logic [7:0] cmd,
                       input logic [7:0] v);
      logic [15:0] s;
      int n;
      reg_wr(ctl_data, {8'h00, v});
      reg_wr(ctl_go, {r_w, a7, cmd});
      repeat (3) @(posedge mclk);
      s = 16'h0001;
      n = 0;
      while (s[0] !== 1'b0) begin
         reg_rd(ctl_status, s);
         n++;
         if (n > 3000) begin
            fails++;
            end_of_test();
         end
      end
      nak = s[1];
      reg_rd(ctl_rdata, s);
      got = s[7:0];
   endtask
   task automatic dev_acc(input logic r_w, input logic [1:0] s, input logic [7:0] v);
      c = 8'($random(seed));
      c[1:0] = s;
      xfer(r_w, {4'h7, straps}, c, v);
      chk({7'h00, nak}, 8'h00);
      if (!r_w && s == sel_drive) latch = v;
      if (!r_w && s == sel_invert) inv = v;
      if (!r_w && s == sel_dir) dir = v;
   endtask
   task automatic read_all;
      for (int k = 0; k < 4; k++) begin
         dev_acc(1'b1, 2'(k), 8'h00);
         chk(got, exp_reg(2'(k)));
      end
   endtask
   task automatic do_reset;
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      latch = drive_reset;
      inv = invert_reset;
      dir = dir_reset;
      chk(p_o, drive_reset);
      chk(p_oe_b, dir_reset);
      read_all();
   endtask
   task automatic alert_is(input logic [7:0] flip, input logic e);
      @(posedge mclk);
      ext <= ext ^ flip;
      repeat (8) @(posedge mclk);
      chk({6'h00, alert_o, alert_oe_b}, {7'h00, e});
   endtask
   // ----------
   // main sequence
   // ----------
   initial begin
      rst_b = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 2'h0;
      wdata = 16'h0000;
      straps = 3'h0;
      ext = 8'h5A;
      fails = 0;
      checks_done = 0;
      seed = 62246;
      do_reset();
      for (i = 0; i < 24; i++) begin
         @(posedge mclk);
         straps <= 3'($random(seed));
         ext <= 8'($random(seed));
         repeat (6) @(posedge mclk);
         r = 2'($random(seed));
         d = 8'($random(seed));
         dev_acc(1'b0, r, d);
         dev_acc(1'b1, r, 8'h00);
         chk(got, exp_reg(r));
         chk(p_o, latch);
         chk(p_oe_b, dir);
      end
      for (i = 0; i < 7; i++) begin
         xfer(1'b0, {4'h7, straps} ^ (7'h01 << i), 8'h01, ~latch);
         chk({7'h00, nak}, 8'h01);
      end
      read_all();
      dev_acc(1'b0, sel_pin_level, ~exp_reg(2'h0));
      read_all();
      dev_acc(1'b0, sel_dir, 8'hFE);
      dev_acc(1'b1, sel_pin_level, 8'h00);
      alert_is(8'h00, 1'b1);
      alert_is(8'h01, 1'b1);
      alert_is(8'h80, 1'b0);
      alert_is(8'h80, 1'b1);
      alert_is(8'h40, 1'b0);
      dev_acc(1'b1, sel_pin_level, 8'h00);
      chk(got, exp_reg(2'h0));
      alert_is(8'h00, 1'b1);
      reg_wr(ctl_data, 16'h0000);
      reg_wr(ctl_go, {1'b0, 4'h7, straps, 8'h01});
      repeat (60) @(posedge mclk);
      do_reset();
      end_of_test();
   end
endmodule // i2c_eight_bit_port_expander_regs_tb
